// ===== rtl/emfa_regs.svh
// Constants for the event message arbiter: word layout and sizing.
`ifndef EMFA_REGS_SVH
`define EMFA_REGS_SVH
`define EMFA_WORD_W      64
`define EMFA_ID_W        8
`define EMFA_ID_LSB      56
`define EMFA_PAYLOAD_W   56
`define EMFA_NUM_SRC     4
`define EMFA_LOCAL_DEPTH 4
`define EMFA_OUT_DEPTH   32
`define EMFA_TS_W        64
`endif

// ===== rtl/emfa_pkg.sv
// Types for the event message arbiter.
package emfa_pkg;
   typedef logic [63:0] emfa_word_t;
   typedef struct packed {
      logic [7:0]  id;
      logic [55:0] payload;
   } emfa_event_s;
   typedef enum logic [1:0] {
      EMFA_IDLE = 2'b00,
      EMFA_TS   = 2'b01,
      EMFA_EVT  = 2'b10
   } emfa_state_e;
endpackage

// ===== rtl/emfa_arbiter.sv
// Event message arbiter: per-source queues merged round-robin into one outbound queue.
//
// Behaviour
// - Event is one 64-bit word; top eight bits carry the source identifier.
// - When a source's write condition holds, its packed word enters its local buffer unless that buffer is full.
// - Each source exposes its fixed identifier and embeds it in its packed word.
// - A local buffer per source holds pending words; a push into a full buffer is dropped and flagged on evt_drop_o.
// - One writer slot per source; granted only when round-robin counter equals its id.
// - Granted slot writes timestamp word then its event word to outbound queue.
// - Only one slot drives the outbound queue at any time.
// - Timestamp records write time, not arrival; bursts drain over several rounds.
`timescale 1ns/10ps
`include "emfa_regs.svh"

module emfa_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // Fill side
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   // Drain side
   output logic                  out_valid_o,
   output logic [WIDTH-1:0]      out_data_o,
   input  wire logic             out_ready_i
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_q];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // A count that drifts from the pointers would hand out stale words or lose new ones.
   fifo_bound_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      cnt_q <= (AW+1)'(DEPTH))
      else $error("buffer count beyond its depth");
   fifo_fill_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (push && !pop) |=> (cnt_q == $past(cnt_q) + 1'b1))
      else $error("accepted word not counted");
   fifo_drain_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (pop && !push) |=> (cnt_q == $past(cnt_q) - 1'b1))
      else $error("drained word not counted");
endmodule

module emfa_arbiter #(
   parameter int NUM_SRC     = `EMFA_NUM_SRC,
   parameter int LOCAL_DEPTH = `EMFA_LOCAL_DEPTH,
   parameter int OUT_DEPTH   = `EMFA_OUT_DEPTH
) (
   // Clock and reset
   input  wire logic                              clk_i,
   input  wire logic                              reset_n_i,
   // Event sources
   input  wire logic [NUM_SRC-1:0]                evt_cond_i,
   input  wire logic [NUM_SRC-1:0][`EMFA_PAYLOAD_W-1:0] evt_payload_i,
   output logic [NUM_SRC-1:0][`EMFA_ID_W-1:0]     evt_id_o,
   output logic [NUM_SRC-1:0]                     evt_drop_o,
   // Outbound host queue
   output logic                                   host_valid_o,
   output logic [`EMFA_WORD_W-1:0]                host_data_o,
   input  wire logic                              host_ready_i
);
   typedef logic [`EMFA_ID_W-1:0] id_t;

   emfa_pkg::emfa_event_s        evt_word [NUM_SRC];
   logic [NUM_SRC-1:0]           loc_ready;
   logic [NUM_SRC-1:0]           loc_valid;
   logic [NUM_SRC-1:0]           loc_pop;
   emfa_pkg::emfa_word_t         loc_data [NUM_SRC];
   logic [NUM_SRC-1:0]           grant;
   emfa_pkg::emfa_state_e        state_q;
   id_t                          rr_q;
   logic [`EMFA_TS_W-1:0]        ts_q;
   emfa_pkg::emfa_word_t         out_word;
   logic                         out_push;
   logic                         out_ready;
   emfa_pkg::emfa_word_t         cur_data;
   logic                         cur_valid;
   logic                         q_valid;
   emfa_pkg::emfa_word_t         q_data;

   for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
      always_comb begin
         evt_word[s].id      = id_t'(s);
         evt_word[s].payload = evt_payload_i[s];
      end
      // Local buffer absorbs bursts while this source waits for its turn.
      emfa_fifo #(
         .WIDTH (`EMFA_WORD_W),
         .DEPTH (LOCAL_DEPTH)
      ) u_local (
         .clk_i       (clk_i),
         .reset_n_i   (reset_n_i),
         .in_valid_i  (evt_cond_i[s]),
         .in_data_i   (evt_word[s]),
         .in_ready_o  (loc_ready[s]),
         .out_valid_o (loc_valid[s]),
         .out_data_o  (loc_data[s]),
         .out_ready_i (loc_pop[s])
      );
      assign grant[s]   = (rr_q == id_t'(s));
      assign loc_pop[s] = grant[s] && (state_q == emfa_pkg::EMFA_EVT) && out_ready;
      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            evt_id_o[s]   <= '0;
            evt_drop_o[s] <= 1'b0;
         end else begin
            evt_id_o[s]   <= id_t'(s);
            evt_drop_o[s] <= evt_cond_i[s] && !loc_ready[s];
         end
      end
      // Every source reports its own identifier from the first edge after reset.
      id_out_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
         1'b1 |=> (evt_id_o[s] == id_t'(s)))
         else $error("source id output wrong");
      // A refused push is reported one cycle later; an accepted one never is.
      drop_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
         evt_cond_i[s] |=> (evt_drop_o[s] == !$past(loc_ready[s])))
         else $error("drop flag disagrees with buffer state");
   end

   // Only the granted slot's buffer is selected, so the queue has a single writer.
   always_comb begin
      cur_data  = '0;
      cur_valid = 1'b0;
      for (int s = 0; s < NUM_SRC; s++) begin
         if (grant[s]) begin
            cur_data  = loc_data[s];
            cur_valid = loc_valid[s];
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ts_q <= '0;
      end else begin
         ts_q <= ts_q + 1'b1;
      end
   end

   // A busy slot costs three cycles and an idle one a single cycle. A source that keeps
   // pushing faster than its turn comes round fills its local buffer, and the events
   // beyond its depth are lost and flagged on the drop output.
   // Slot sequencer: timestamp word, then event word, then next identifier.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= emfa_pkg::EMFA_IDLE;
         rr_q    <= '0;
      end else begin
         case (state_q)
            emfa_pkg::EMFA_IDLE: begin
               if (cur_valid) begin
                  state_q <= emfa_pkg::EMFA_TS;
               end else begin
                  rr_q <= (rr_q == id_t'(NUM_SRC-1)) ? '0 : rr_q + 1'b1;
               end
            end
            emfa_pkg::EMFA_TS: begin
               if (out_ready) begin
                  state_q <= emfa_pkg::EMFA_EVT;
               end
            end
            emfa_pkg::EMFA_EVT: begin
               if (out_ready) begin
                  state_q <= emfa_pkg::EMFA_IDLE;
                  rr_q    <= (rr_q == id_t'(NUM_SRC-1)) ? '0 : rr_q + 1'b1;
               end
            end
            default: begin
               state_q <= emfa_pkg::EMFA_IDLE;
            end
         endcase
      end
   end

   // Timestamp is taken at the write, so it shows queue time, not arrival.
   assign out_push = (state_q == emfa_pkg::EMFA_TS) || (state_q == emfa_pkg::EMFA_EVT);
   assign out_word = (state_q == emfa_pkg::EMFA_TS) ? ts_q : cur_data;

   emfa_fifo #(
      .WIDTH (`EMFA_WORD_W),
      .DEPTH (OUT_DEPTH)
   ) u_out (
      .clk_i       (clk_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (out_push),
      .in_data_i   (out_word),
      .in_ready_o  (out_ready),
      .out_valid_o (q_valid),
      .out_data_o  (q_data),
      .out_ready_i (!host_valid_o || host_ready_i)
   );

   // Output register keeps host-facing ports straight from flip-flops.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         host_valid_o <= 1'b0;
         host_data_o  <= '0;
      end else if (!host_valid_o || host_ready_i) begin
         host_valid_o <= q_valid;
         host_data_o  <= q_data;
      end
   end

   sequence ts_then_evt_s;
      (state_q == emfa_pkg::EMFA_TS && out_ready) ##1 (state_q == emfa_pkg::EMFA_EVT);
   endsequence

   two_word_slot_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_q == emfa_pkg::EMFA_TS && out_ready) |-> ts_then_evt_s)
      else $error("timestamp word not followed by event word");
   ts_word_value_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_q == emfa_pkg::EMFA_TS) |-> (out_word == ts_q))
      else $error("timestamp word is not the current time");
   single_grant_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      $onehot0(loc_pop))
      else $error("more than one slot drains at once");
   rr_wrap_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_q == emfa_pkg::EMFA_IDLE && !cur_valid && rr_q == id_t'(NUM_SRC-1))
      |=> (rr_q == '0))
      else $error("round robin did not wrap");
   rr_advance_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_q == emfa_pkg::EMFA_EVT && out_ready && rr_q != id_t'(NUM_SRC-1))
      |=> (rr_q == $past(rr_q) + 1'b1))
      else $error("round robin did not advance after slot");
   empty_skip_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_q == emfa_pkg::EMFA_IDLE && !cur_valid) |=> (state_q == emfa_pkg::EMFA_IDLE))
      else $error("empty slot started a write");
   evt_id_field_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_q == emfa_pkg::EMFA_EVT && out_ready)
      |-> (out_word[`EMFA_WORD_W-1:`EMFA_ID_LSB] == rr_q))
      else $error("event word id does not match grant");
   evt_pop_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (|loc_pop) |-> (loc_pop[rr_q[$clog2(NUM_SRC > 1 ? NUM_SRC : 2)-1:0]]
      && state_q == emfa_pkg::EMFA_EVT))
      else $error("buffer drained outside its turn");
   // A slot opens only on a pending word and keeps its grant until both words are written.
   sequence slot_open_s;
      state_q == emfa_pkg::EMFA_IDLE && cur_valid;
   endsequence

   slot_open_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      slot_open_s |=> (state_q == emfa_pkg::EMFA_TS && $stable(rr_q)))
      else $error("slot did not open on a pending word");
   slot_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_q == emfa_pkg::EMFA_TS) |=> $stable(rr_q))
      else $error("grant moved inside a slot");
   ts_count_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      1'b1 |=> (ts_q == $past(ts_q) + 1'b1))
      else $error("timestamp counter skipped");
   host_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (host_valid_o && !host_ready_i) |=> (host_valid_o && $stable(host_data_o)))
      else $error("host word changed before it was taken");
   evt_valid_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_q == emfa_pkg::EMFA_EVT) |-> cur_valid)
      else $error("event word slot found its buffer empty");
   rr_range_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      rr_q <= id_t'(NUM_SRC-1))
      else $error("round robin beyond highest id");
   rr_step_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_q == emfa_pkg::EMFA_IDLE && !cur_valid && rr_q != id_t'(NUM_SRC-1))
      |=> (rr_q == $past(rr_q) + 1'b1))
      else $error("empty slot did not pass the turn on");
endmodule

// ===== bench/emfa_host_model.sv
// Host-side reader of the outbound queue that takes words at a chosen pace.
`timescale 1ns/10ps
module emfa_host_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // Pace control
   input  wire logic        hold_i,
   input  wire logic        slow_i,
   // Outbound host queue
   input  wire logic        valid_i,
   input  wire logic [63:0] data_i,
   output logic             ready_o
);
   logic [63:0] words [$];
   // Ready moves just after an edge, so a word is taken only where valid and ready meet.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ready_o <= 1'b0;
      end else begin
         ready_o <= !hold_i && (!slow_i || !ready_o);
      end
   end
   // The bench pops this queue, so it is filled by a plain process rather than always_ff.
   always @(posedge clk_i) begin
      if (reset_n_i && valid_i && ready_o) begin
         words.push_back(data_i);
      end
   end
endmodule

// ===== bench/test_emfa_arbiter.sv
// Self-checking bench for the event message arbiter against a host reader model.
`timescale 1ns/10ps
`include "emfa_regs.svh"
module test_emfa_arbiter;
   localparam int NS = `EMFA_NUM_SRC;
   logic                               clk_i = 1'b0;
   logic                               reset_n_i = 1'b0;
   logic [NS-1:0]                      evt_cond_i = '0;
   logic [NS-1:0][`EMFA_PAYLOAD_W-1:0] evt_payload_i = '0;
   logic [NS-1:0][`EMFA_ID_W-1:0]      evt_id_o;
   logic [NS-1:0]                      evt_drop_o;
   logic                               host_valid_o;
   logic                               host_ready_i;
   logic [`EMFA_WORD_W-1:0]            host_data_o;
   logic                               hold = 1'b0;
   logic                               slow = 1'b0;
   int                                 fails = 0;
   int                                 comparisons = 0;
   int                                 drops = 0;
   logic [55:0]                        exp_q [NS][$];
   logic [63:0]                        last_ts = '0;

   emfa_arbiter emfa_arbiter_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .evt_cond_i(evt_cond_i), .evt_payload_i(evt_payload_i), .evt_id_o(evt_id_o),
      .evt_drop_o(evt_drop_o), .host_valid_o(host_valid_o), .host_data_o(host_data_o),
      .host_ready_i(host_ready_i));
   emfa_host_model emfa_host_model_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .hold_i(hold), .slow_i(slow), .valid_i(host_valid_o), .data_i(host_data_o),
      .ready_o(host_ready_i));

   initial begin
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) drops <= drops + $countones(evt_drop_o);

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Payload carries the source in byte 0 and a sequence number in byte 1.
   task automatic push(input logic [NS-1:0] mask, input logic [7:0] k);
      @(posedge clk_i);
      for (int s = 0; s < NS; s++) begin
         evt_cond_i[s] <= mask[s];
         evt_payload_i[s] <= {40'h0, k, 8'(s)};
         if (mask[s]) exp_q[s].push_back({40'h0, k, 8'(s)});
      end
   endtask
   task automatic idle();
      @(posedge clk_i);
      evt_cond_i <= '0;
   endtask
   task automatic wait_words(input int n);
      for (int i = 0; i < 5000 && emfa_host_model_inst.words.size() < n; i++) @(posedge clk_i);
      chk(64'(emfa_host_model_inst.words.size() >= n), 64'h1);
   endtask
   task automatic take(output logic [63:0] ts, output logic [63:0] ev);
      ts = emfa_host_model_inst.words.pop_front();
      ev = emfa_host_model_inst.words.pop_front();
      chk(64'(ts > last_ts), 64'h1);
      last_ts = ts;
   endtask
   task automatic check_event(output logic [63:0] ev);
      logic [63:0] ts;
      take(ts, ev);
      chk(ev, {6'h0, ev[1:0], exp_q[ev[1:0]].pop_front()});
   endtask

   task automatic t_ids();
      for (int s = 0; s < NS; s++) chk(64'(evt_id_o[s]), 64'(s));
   endtask
   task automatic t_all();
      logic [63:0] ev;
      logic [7:0]  prev;
      push(4'hF, 8'h01);
      idle();
      wait_words(2 * NS);
      for (int i = 0; i < NS; i++) begin
         check_event(ev);
         if (i > 0) chk(64'(ev[63:56]), 64'((prev + 1) % NS));
         prev = ev[63:56];
      end
   endtask
   // A burst on one source overflows its buffer; what survives keeps order and lags.
   task automatic t_burst();
      logic [63:0] ts, ev, pts;
      logic [7:0]  pk;
      int          n;
      int          d0;
      d0 = drops;
      pk = '0;
      slow <= 1'b1;
      for (int k = 0; k < 8; k++) push(4'h4, 8'(k));
      idle();
      repeat (2) @(posedge clk_i);
      n = 8 - (drops - d0);
      chk(64'(drops > d0), 64'h1);
      wait_words(2 * n);
      for (int i = 0; i < n; i++) begin
         pts = last_ts;
         take(ts, ev);
         chk(64'(ev[63:56]), 64'h2);
         chk(64'(ev[7:0]), 64'h2);
         if (i > 0) chk(64'(ts - pts > 2), 64'h1);
         if (i > 0) chk(64'(ev[15:8] > pk), 64'h1);
         pk = ev[15:8];
      end
      exp_q[2].delete();
   endtask
   // The host holds off until the outbound queue refuses, then drains slowly.
   task automatic t_fill();
      logic [63:0] ev, held;
      int          d0;
      d0 = drops;
      hold <= 1'b1;
      for (int k = 0; k < 4; k++) push(4'hF, 8'h10 + 8'(k));
      idle();
      repeat (60) @(posedge clk_i);
      for (int k = 0; k < 4; k++) push(4'hF, 8'h20 + 8'(k));
      idle();
      repeat (20) @(posedge clk_i);
      held = host_data_o;
      chk(64'(host_valid_o), 64'h1);
      repeat (5) @(posedge clk_i);
      chk(host_data_o, held);
      hold <= 1'b0;
      wait_words(64);
      for (int i = 0; i < 32; i++) check_event(ev);
      chk(64'(drops), 64'(d0));
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      // The scenarios need a few hundred cycles; ten thousand catches a hang early.
      #100us;
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      t_ids();
      t_all();
      t_burst();
      t_fill();
      report_and_stop();
   end
endmodule
